// file: core/urxdr_core.sv
/*
 * receive data recovery of an asynchronous nrz serial line, with standby
 * and wakeup, reached over ahb-lite. assumes a one-per-oversample pulse on
 * oversample_tick from a baud generator on hclk, and a remote transmitter.
 */
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
// Function
// - sample the line once per oversample tick, sixteen ticks per bit
// - restart tick count after start bit and on valid one-to-zero data edge
// - start search: zero after three ones, then count ticks up to 16
// - verify start at ticks 3,5,7; fail on two ones; single one flags noise
// - failed start verification resets tick count and restarts the search
// - data bit is majority of ticks 8,9,10; disagreement flags noise
// - start bit ones at ticks 8-10 flag noise, bit still taken as start
// - stop bit from ticks 8-10: majority zero is framing error, disagreement noise
// - no valid one in stop position, breaks included, sets framing error
// - framing error sets in the same cycle as the holding full flag
// - stop bit starting as late as tick 8 still received cleanly
// - stop bit ending as early as tick 10 still received cleanly
// - standby bit puts receiver in standby and masks its request
// - address-mark wake: msb one clears standby and sets holding full
// - idle-line wake: idle character clears standby
// - waking idle character sets neither idle flag nor holding full
// - origin setting picks where counting of idle ones begins
// - idle wake never ends standby on a line already idle; the idle count must reach its threshold again
// - length bit: one gives nine data bits, zero gives eight
// - wake select: one address mark, zero idle line; cleared by reset
// - origin one counts after stop bit, zero after start bit
`timescale 1ns/1ns
`default_nettype none
`include "urxdr_map.svh"

module urxdr_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic oversample_tick,
   input wire logic serial_in_pin,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic rx_request
);

   urxdr_pkg::urxdr_reg_t q;
   urxdr_pkg::urxdr_reg_t n;

   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj3

   function automatic logic noisy3(input logic [2:0] s);
      noisy3 = (s != 3'h0) && (s != 3'h7);
   endfunction : noisy3

   function automatic logic [31:0] rd_mux(input urxdr_pkg::urxdr_reg_t r, input logic [7:0] a);
      rd_mux = 32'h0;
      if (a == `URXDR_CTRL_OFS) begin
         rd_mux[`URXDR_CTRL_CHAR9] = r.char9;
         rd_mux[`URXDR_CTRL_WAKE] = r.wake_sel;
         rd_mux[`URXDR_CTRL_ORIGIN] = r.quiet_count_origin;
         rd_mux[`URXDR_CTRL_STANDBY] = r.receiver_standby;
      end else if (a == `URXDR_STAT_OFS) begin
         rd_mux[`URXDR_STAT_FULL] = r.rx_holding_full;
         rd_mux[`URXDR_STAT_FE] = r.stop_bit_error_flag;
         rd_mux[`URXDR_STAT_NF] = r.line_glitch_flag;
         rd_mux[`URXDR_STAT_IDLE] = r.idle_flag;
      end else if (a == `URXDR_DATA_OFS) begin
         rd_mux[8:0] = r.data;
      end
   endfunction : rd_mux

   logic s;
   logic [4:0] nrt;
   logic wrap;
   logic resync;
   logic [7:0] idle_thr;
   logic take;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = q;
      s = q.sync2;
      nrt = (q.rt == `URXDR_TICKS_PER_BIT) ? 5'h01 : q.rt + 5'h01;
      wrap = (q.rt == `URXDR_TICKS_PER_BIT);
      resync = 1'b0;
      take = 1'b0;
      idle_thr = q.char9 ? `URXDR_IDLE_TICKS9 : `URXDR_IDLE_TICKS8;
      if (clk_en) begin
         n.sync1 = serial_in_pin;
         n.sync2 = q.sync1;
         n.rx_request = q.rx_holding_full & ~q.receiver_standby;
         n.hreadyout = 1'b1;
         n.hresp = 1'b0;
         // bus data phase
         n.dp_wr = 1'b0;
         if (q.dp_wr && q.dp_addr == `URXDR_CTRL_OFS) begin
            n.char9 = hwdata[`URXDR_CTRL_CHAR9];
            n.wake_sel = hwdata[`URXDR_CTRL_WAKE];
            n.quiet_count_origin = hwdata[`URXDR_CTRL_ORIGIN];
            n.receiver_standby = hwdata[`URXDR_CTRL_STANDBY];
         end
         if (q.dp_wr && q.dp_addr == `URXDR_STAT_OFS) begin
            n.rx_holding_full = q.rx_holding_full & ~hwdata[`URXDR_STAT_FULL];
            n.stop_bit_error_flag = q.stop_bit_error_flag & ~hwdata[`URXDR_STAT_FE];
            n.line_glitch_flag = q.line_glitch_flag & ~hwdata[`URXDR_STAT_NF];
            n.idle_flag = q.idle_flag & ~hwdata[`URXDR_STAT_IDLE];
         end
         // bus address phase
         if (hsel && htrans[1] && hready) begin
            n.dp_wr = hwrite;
            n.dp_addr = haddr[7:0];
            if (!hwrite) begin
               n.hrdata = rd_mux(q, haddr[7:0]);
               if (haddr[7:0] == `URXDR_DATA_OFS) begin
                  n.rx_holding_full = 1'b0;
                  n.stop_bit_error_flag = 1'b0;
                  n.line_glitch_flag = 1'b0;
               end
            end
         end
         // receiver, one step per oversample tick
         if (oversample_tick) begin
            n.hist = {q.hist[1:0], s};
            n.last_samp = s;
            if (q.st == urxdr_pkg::URXDR_SEARCH) begin
               if (!s && q.hist == 3'h7) begin
                  n.st = urxdr_pkg::URXDR_START;
                  n.rt = 5'h01;
                  n.noise = 1'b0;
                  n.samp = 3'h0;
                  n.edge_armed = 1'b0;
               end
            end else begin
               resync = (q.st == urxdr_pkg::URXDR_DATA) && q.edge_armed && q.last_samp && !s;
               if (resync) begin
                  n.rt = 5'h01;
                  n.edge_armed = 1'b0;
                  wrap = (q.rt > `URXDR_RT_D3);
               end else begin
                  n.rt = nrt;
               end
               if (wrap) begin
                  if (q.st == urxdr_pkg::URXDR_START) begin
                     n.st = urxdr_pkg::URXDR_DATA;
                     n.bitn = 4'h0;
                     n.idle_armed = 1'b1;
                  end else if (q.st == urxdr_pkg::URXDR_DATA && q.bitn == (q.char9 ? 4'h9 : 4'h8)) begin
                     n.st = urxdr_pkg::URXDR_STOP;
                  end
               end
               if (!resync && (nrt == `URXDR_RT_V1 || nrt == `URXDR_RT_D1)) begin
                  n.samp = {2'h0, s};
               end else if (!resync && (nrt == `URXDR_RT_V2 || nrt == `URXDR_RT_D1 + 5'h01)) begin
                  n.samp = {q.samp[1:0], s};
               end
               if (!resync && q.st == urxdr_pkg::URXDR_START && nrt == `URXDR_RT_V3) begin
                  if (maj3({q.samp[1:0], s})) begin
                     n.st = urxdr_pkg::URXDR_SEARCH;
                     n.rt = 5'h00;
                  end else begin
                     n.noise = q.noise | noisy3({q.samp[1:0], s});
                  end
               end
               if (!resync && nrt == `URXDR_RT_D3) begin
                  unique case (q.st)
                     urxdr_pkg::URXDR_START: begin
                        n.noise = q.noise | ({q.samp[1:0], s} != 3'h0);
                     end
                     urxdr_pkg::URXDR_DATA: begin
                        n.shreg = {maj3({q.samp[1:0], s}), q.shreg[8:1]};
                        n.noise = q.noise | noisy3({q.samp[1:0], s});
                        n.edge_armed = maj3({q.samp[1:0], s});
                        n.bitn = q.bitn + 4'h1;
                     end
                     urxdr_pkg::URXDR_STOP: begin
                        // a late or early stop bit still covers ticks 8-10
                        n.st = urxdr_pkg::URXDR_SEARCH;
                        n.rt = 5'h00;
                        take = !q.receiver_standby || (q.wake_sel && q.shreg[8]);
                        if (take) begin
                           n.rx_holding_full = 1'b1;
                           n.stop_bit_error_flag = ~maj3({q.samp[1:0], s});
                           n.line_glitch_flag = q.noise | noisy3({q.samp[1:0], s});
                           n.data = q.char9 ? q.shreg : {1'b0, q.shreg[8:1]};
                        end
                        if (q.receiver_standby && q.wake_sel && q.shreg[8]) begin
                           n.receiver_standby = 1'b0;
                        end
                     end
                     default: begin
                        n.st = urxdr_pkg::URXDR_SEARCH;
                     end
                  endcase
               end
            end
            // idle counting: ones run from after start or after stop
            if (!s) begin
               n.idle_cnt = 8'h00;
            end else if ((q.st == urxdr_pkg::URXDR_SEARCH ||
                          (!q.quiet_count_origin && q.st != urxdr_pkg::URXDR_START))
                         && q.idle_cnt != idle_thr) begin
               n.idle_cnt = q.idle_cnt + 8'h01;
               if (q.idle_cnt + 8'h01 == idle_thr) begin
                  if (n.receiver_standby && !q.wake_sel) begin
                     n.receiver_standby = 1'b0;
                  end else if (q.idle_armed) begin
                     n.idle_flag = 1'b1;
                     n.idle_armed = 1'b0;
                  end
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.sync1 <= 1'b1;
         q.sync2 <= 1'b1;
         q.last_samp <= 1'b1;
         q.st <= urxdr_pkg::URXDR_SEARCH;
         q.hreadyout <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign hrdata = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign rx_request = q.rx_request;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_start_edge;
      clk_en && oversample_tick && q.st == urxdr_pkg::URXDR_SEARCH && !q.sync2 && q.hist == 3'h7;
   endsequence

   sequence s_ctrl_write;
      clk_en && q.dp_wr && q.dp_addr == `URXDR_CTRL_OFS;
   endsequence

   a_start_edge_go: assert property (s_start_edge |=> q.st == urxdr_pkg::URXDR_START && q.rt == 5'h01)
      else $error("start edge not followed by start state at tick one");
   a_search_needs_edge: assert property (q.st == urxdr_pkg::URXDR_SEARCH ##1 q.st == urxdr_pkg::URXDR_START
      |-> $past(q.hist) == 3'h7 && !$past(q.sync2))
      else $error("start state entered without three ones then zero");
   a_rt_in_range: assert property (q.st != urxdr_pkg::URXDR_SEARCH |-> q.rt >= 5'h01 && q.rt <= 5'h10)
      else $error("tick count out of range");
   a_fe_with_full: assert property ($rose(q.stop_bit_error_flag) |-> q.rx_holding_full
      && $past(q.st) == urxdr_pkg::URXDR_STOP)
      else $error("framing flag set apart from holding full");
   a_verify_fail: assert property (clk_en && oversample_tick && q.st == urxdr_pkg::URXDR_START
      && q.rt == 5'h06 && q.sync2 && (q.samp[0] | q.samp[1]) |=> q.st == urxdr_pkg::URXDR_SEARCH)
      else $error("failed start verification did not restart search");
   a_standby_mask: assert property (clk_en && q.receiver_standby |=> !rx_request)
      else $error("request raised during standby");
   a_ctrl_write: assert property (s_ctrl_write |=> q.char9 == $past(hwdata[`URXDR_CTRL_CHAR9])
      && q.wake_sel == $past(hwdata[`URXDR_CTRL_WAKE]))
      else $error("control write not stored");
   a_addr_wake: assert property ($fell(q.receiver_standby) && $past(q.wake_sel) && !$past(q.dp_wr)
      |-> q.rx_holding_full)
      else $error("address mark wake without holding full");
   a_idle_wake_quiet: assert property ($fell(q.receiver_standby) && !$past(q.wake_sel) && !$past(q.dp_wr)
      |-> !$rose(q.idle_flag) && !$rose(q.rx_holding_full))
      else $error("waking idle character raised a flag");
   a_bus_ready: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");

endmodule : urxdr_core

`default_nettype wire

// file: common/urxdr_map.svh
/*
 * register offsets, field positions and sample tick counts
 * of the receive data recovery block. assumes a 32-bit ahb-lite word map.
 */
`ifndef URXDR_MAP_SVH
`define URXDR_MAP_SVH

`define URXDR_CTRL_OFS 8'h00
`define URXDR_STAT_OFS 8'h04
`define URXDR_DATA_OFS 8'h08

`define URXDR_CTRL_CHAR9 0
`define URXDR_CTRL_WAKE 1
`define URXDR_CTRL_ORIGIN 2
`define URXDR_CTRL_STANDBY 3

`define URXDR_STAT_FULL 0
`define URXDR_STAT_FE 1
`define URXDR_STAT_NF 2
`define URXDR_STAT_IDLE 3

`define URXDR_TICKS_PER_BIT 5'h10
`define URXDR_RT_V1 5'h03
`define URXDR_RT_V2 5'h05
`define URXDR_RT_V3 5'h07
`define URXDR_RT_D1 5'h08
`define URXDR_RT_D3 5'h0A
`define URXDR_IDLE_TICKS8 8'hA0
`define URXDR_IDLE_TICKS9 8'hB0

`endif

// file: common/urxdr_pkg.sv
/*
 * types of the receive data recovery block: state codes and state record.
 * assumes urxdr_map.svh for all numeric constants.
 */
package urxdr_pkg;

   typedef enum logic [3:0] {
      URXDR_SEARCH = 4'h1,
      URXDR_START = 4'h2,
      URXDR_DATA = 4'h4,
      URXDR_STOP = 4'h8
   } urxdr_state_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [2:0] hist;
      logic last_samp;
      urxdr_state_t st;
      logic [4:0] rt;
      logic [3:0] bitn;
      logic [8:0] shreg;
      logic [2:0] samp;
      logic noise;
      logic edge_armed;
      logic [7:0] idle_cnt;
      logic idle_armed;
      logic char9;
      logic wake_sel;
      logic quiet_count_origin;
      logic receiver_standby;
      logic rx_holding_full;
      logic stop_bit_error_flag;
      logic line_glitch_flag;
      logic idle_flag;
      logic [8:0] data;
      logic rx_request;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic dp_wr;
      logic [7:0] dp_addr;
   } urxdr_reg_t;

endpackage : urxdr_pkg

// file: bench/urxdr_tx_model.sv
/*
 * behavioural remote asynchronous transmitter driving the receive line.
 * assumes oversample_tick pulses on hclk, sixteen per nominal bit time.
 */
`timescale 1ns/1ns
`default_nettype none

module urxdr_tx_model (
   input wire logic hclk,
   input wire logic oversample_tick,
   output var logic serial_in_pin
);
   initial serial_in_pin = 1'b1;

   // one line change per tick, just after the tick edge
   task automatic step(input logic v);
      do @(posedge hclk); while (oversample_tick !== 1'b1);
      serial_in_pin <= v;
   endtask : step

   // hold the line at one level for k ticks
   task automatic hold(input logic v, input int k);
      repeat (k) step(v);
   endtask : hold

   // start, n data bits lsb first, stop; tpb ticks a bit, last ticks for the
   // final data bit, g inverts the line for one tick (negative: none)
   task automatic send(input logic [8:0] d, input int n, input int tpb, input int last,
                       input logic stop_v, input int g);
      int t;
      int b;
      int len;
      logic v;
      t = 0;
      for (b = 0; b < n + 2; b++) begin
         v = (b == 0) ? 1'b0 : (b == n + 1) ? stop_v : d[b - 1];
         len = (b == n) ? last : tpb;
         repeat (len) begin
            step(v ^ (t == g));
            t++;
         end
      end
   endtask : send
endmodule : urxdr_tx_model

`default_nettype wire

// file: bench/urxdr_core_tb.sv
/*
 * self-checking bench of the receive data recovery block.
 * assumes the transmitter model and one oversample tick every fourth clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "urxdr_map.svh"

module urxdr_core_tb;
   localparam logic [7:0] ctl = `URXDR_CTRL_OFS;
   localparam logic [7:0] sts = `URXDR_STAT_OFS;
   localparam logic [7:0] dat = `URXDR_DATA_OFS;
   logic hclk, hresetn, oversample_tick, serial_in_pin, hsel, hwrite, hreadyout, hresp, rx_request;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, tcnt;
   int fails, comparisons, cycles;

   urxdr_core u_urxdr_core (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .oversample_tick(oversample_tick),
      .serial_in_pin(serial_in_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_request(rx_request));
   urxdr_tx_model u_urxdr_tx_model (.hclk(hclk), .oversample_tick(oversample_tick),
      .serial_in_pin(serial_in_pin));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // one oversample tick every fourth clock
   always @(posedge hclk) begin
      tcnt <= tcnt + 2'h1;
      oversample_tick <= (tcnt == 2'h3);
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // single ahb-lite transfer, zero or more wait states
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd & m, exp);
   endtask : rchk

   task automatic verify(input logic [8:0] ed, input logic [2:0] es, input logic req);
      u_urxdr_tx_model.hold(1'b1, 8);
      check({31'h0, rx_request}, {31'h0, req});
      rchk(sts, 32'h7, {29'h0, es});
      rchk(dat, 32'h1FF, {23'h0, ed});
   endtask : verify

   task automatic rx(input logic [8:0] d, input int n, input int tpb, input int last, input logic sv,
                     input int g, input logic [8:0] ed, input logic [2:0] es);
      wr(sts, 32'hF);
      u_urxdr_tx_model.send(d, n, tpb, last, sv, g);
      verify(ed, es, es[0]);
   endtask : rx

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rchk(ctl, 32'hF, 32'h0);
      rchk(sts, 32'hF, 32'h0);
      rchk(8'h10, 32'hFFFFFFFF, 32'h0);
      wr(ctl, 32'h7);
      rchk(ctl, 32'hF, 32'h7);
      wr(ctl, 32'h0);
      check({31'h0, rx_request}, 32'h0);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_frames();
      int g;
      wr(sts, 32'hF);
      u_urxdr_tx_model.hold(1'b0, 4);
      u_urxdr_tx_model.hold(1'b1, 40);
      rchk(sts, 32'h7, 32'h0);
      rx(9'h05A, 8, 16, 16, 1'b1, -1, 9'h05A, 3'h1);
      for (g = 2; g <= 6; g += 2) begin
         rx(9'h0C3, 8, 16, 16, 1'b1, g, 9'h0C3, 3'h5);
      end
      rx(9'h0C3, 8, 16, 16, 1'b1, 8, 9'h0C3, 3'h5);
      rx(9'h0A5, 8, 16, 16, 1'b1, 72, 9'h0A5, 3'h5);
      rx(9'h0A5, 8, 16, 16, 1'b1, 152, 9'h0A5, 3'h5);
      rx(9'h000, 8, 16, 16, 1'b0, -1, 9'h000, 3'h3);
      rx(9'h055, 8, 17, 17, 1'b1, -1, 9'h055, 3'h1);
      rx(9'h000, 8, 16, 23, 1'b1, -1, 9'h000, 3'h1);
      wr(ctl, 32'h1);
      rx(9'h1A5, 9, 16, 16, 1'b1, -1, 9'h1A5, 3'h1);
      wr(ctl, 32'h0);
      wr(sts, 32'hF);
      u_urxdr_tx_model.send(9'h000, 8, 16, 10, 1'b1, -1);
      u_urxdr_tx_model.send(9'h03C, 8, 16, 16, 1'b1, -1);
      verify(9'h03C, 3'h1, 1'b1);
      $display("t_frames done");
   endtask : t_frames

   task automatic t_mark();
      wr(sts, 32'hF);
      wr(ctl, 32'h2);
      u_urxdr_tx_model.send(9'h012, 8, 16, 16, 1'b1, -1);
      wr(ctl, 32'hA);
      u_urxdr_tx_model.send(9'h034, 8, 16, 16, 1'b1, -1);
      u_urxdr_tx_model.hold(1'b1, 8);
      check({31'h0, rx_request}, 32'h0);
      rchk(dat, 32'h1FF, 32'h012);
      rchk(ctl, 32'hF, 32'hA);
      u_urxdr_tx_model.send(9'h080, 8, 16, 16, 1'b1, -1);
      verify(9'h080, 3'h1, 1'b1);
      rchk(ctl, 32'hF, 32'h2);
      $display("t_mark done");
   endtask : t_mark

   task automatic t_idle();
      wr(ctl, 32'h8);
      u_urxdr_tx_model.hold(1'b1, 200);
      rchk(ctl, 32'hF, 32'h0);
      wr(sts, 32'hF);
      u_urxdr_tx_model.hold(1'b0, 4);
      u_urxdr_tx_model.hold(1'b1, 1);
      wr(ctl, 32'h8);
      rchk(ctl, 32'hF, 32'h8);
      u_urxdr_tx_model.hold(1'b1, 200);
      rchk(ctl, 32'hF, 32'h0);
      rchk(sts, 32'hF, 32'h0);
      $display("t_idle done");
   endtask : t_idle

   task automatic t_origin();
      int o;
      for (o = 0; o < 2; o++) begin
         wr(ctl, {29'h0, o[0], 2'h0});
         wr(sts, 32'hF);
         u_urxdr_tx_model.send(9'h0FF, 8, 16, 16, 1'b1, -1);
         u_urxdr_tx_model.hold(1'b1, 30);
         rchk(sts, 32'h8, (o == 0) ? 32'h8 : 32'h0);
         u_urxdr_tx_model.hold(1'b1, 150);
         rchk(sts, 32'h8, 32'h8);
         rchk(dat, 32'h1FF, 32'h0FF);
      end
      $display("t_origin done");
   endtask : t_origin

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      comparisons = 0;
      cycles = 0;
      tcnt = 2'h0;
      oversample_tick = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_frames();
      t_mark();
      t_idle();
      t_origin();
      summarize();
   end
endmodule : urxdr_core_tb

`default_nettype wire
